/* File: core/eocsr_responder.sv */
// Status poll, configuration and counter flag responder for the operations channel.
//
// Notes on behaviour
// RULE1 - After a timeout configuration, send 133 carrying the applied 12-bit timeout.
// RULE2 - If a configuration cannot be done, set unable-to-comply and report current settings.
// RULE3 - Read-only timeout request changes nothing and reports present values.
// RULE4 - Timeout response carries date octets 5-14 and time octets 15-22.
// RULE5 - Central terminal broadcasts the management flow request 18 to every unit.
// RULE6 - Remote flow enabled after reset; request octet 2 bit 0: 0 enable, 1 disable.
// RULE7 - Flow disabled: regenerator ignores remote-originated requests 2 to 12.
// RULE8 - Read-only management request ignores other fields and reports current setting.
// RULE9 - Answer 18 with 146: unable-to-comply octet 2 bit 0, flow status octet 3 bit 0.
// RULE10 - Status poll 11 is answered with some of 139, 140, 141 and 137.
// RULE11 - Active alarm, fault or maintenance conditions add their matching status messages.
// RULE12 - Performance changes other than margin since the last poll add their messages.
// RULE13 - Nothing active and nothing changed: answer with 139 only.
// RULE14 - Two-pair mode may send 139, 140 and 141 once per pair.
// RULE15 - Full status 12 sends network, customer, then maintenance; two-pair loop 1 first.
// RULE16 - 139 carries network margin, customer margin and loop identifier 1 or 2.
// RULE17 - Application-interface side margin is zero: network at central, customer at remote.
// RULE18 - Overflow bits 7 and 5 set when any modulo counter wrapped since last 140.
// RULE19 - Reset bits 6 and 4 set when any modulo counter was reset, power-up included.
// RULE20 - Bits 7 and 6 clear after a 140 goes to the central terminal.
// RULE21 - Bits 5 and 4 clear after a 140 goes to the remote terminal.
// RULE22 - Device fault flag follows hardware self-test or software fault indications.
// RULE23 - Unknown message identifiers are dropped with no answer and no change.
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "eocsr_defs.svh"

module eocsr_responder
   import eocsr_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Avalon-MM register slave.
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Received message octets, first octet is the identifier.
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxLast,
   input wire logic rxRemote,
   output logic rxReady,
   // Response message octets.
   output logic txValid,
   output logic [7:0] txData,
   output logic txLast,
   output logic txLoop,
   input wire logic txReady,
   // Line condition inputs, index 0 is loop 1.
   input wire logic [1:0][7:0] snrNet,
   input wire logic [1:0][7:0] snrCus,
   input wire logic [1:0] netAlarm,
   input wire logic [1:0] cusAlarm,
   input wire logic maintActive,
   input wire logic [1:0] netPerfChg,
   input wire logic [1:0] cusPerfChg,
   input wire logic selfTestFail,
   input wire logic cntWrap,
   input wire logic cntReset,
   // Flags for the framer of the performance status bodies.
   output logic [3:0] cntFlags,
   output logic devFaultFlag
);

   eocsr_state_s_t s_q;
   eocsr_state_s_t s_d;

   // -----------------------------------------------------------------
   // Response octet builder
   // -----------------------------------------------------------------

   // Length of a response message in octets.
   function automatic logic [4:0] msgLen(input logic [7:0] id);
      case (id)
         `EOCSR_ID_LBT_RSP: msgLen = `EOCSR_LEN_LBT;
         `EOCSR_ID_MGT_RSP: msgLen = `EOCSR_LEN_MGT;
         `EOCSR_ID_SNR_RSP: msgLen = `EOCSR_LEN_SNR;
         default: msgLen = `EOCSR_LEN_ONE;
      endcase
   endfunction

   // Octet i (zero based) of a response. Bodies of 140, 141 and 137 are
   // filled in by the framer, so only their identifier comes from here.
   function automatic logic [7:0] octetAt(input eocsr_state_s_t s, input logic [7:0] id,
                                          input logic lp, input logic [4:0] i);
      logic [7:0] o;
      o = 8'h00;

      if (i == 5'd0) begin
         o = id;
      end else if (id == `EOCSR_ID_LBT_RSP) begin
         if (i == 5'd1) begin
            o[`EOCSR_BIT_UTC] = s.unable_to_comply_flag; // see RULE2
         end else if (i == 5'd2) begin
            o = {4'h0, s.lbTimeout[11:8]}; // see RULE1
         end else if (i == 5'd3) begin
            o = s.lbTimeout[7:0]; // see RULE1
         end else begin
            o = s.rxBuf[i - `EOCSR_DT_SHIFT]; // see RULE4
         end
      end else if (id == `EOCSR_ID_MGT_RSP) begin
         if (i == 5'd1) begin
            o[`EOCSR_BIT_UTC] = s.unable_to_comply_flag; // see RULE9
         end else begin
            o[`EOCSR_BIT_FLOW] = s.flowDis; // see RULE9
         end
      end else if (id == `EOCSR_ID_SNR_RSP) begin
         if (i == 5'd1) begin
            o = s.ctrl[`EOCSR_CTRL_CENTRAL] ? 8'h00 : snrNet[lp]; // see RULE16 see RULE17
         end else if (i == 5'd2) begin
            o = s.ctrl[`EOCSR_CTRL_CENTRAL] ? snrCus[lp] : 8'h00; // see RULE16 see RULE17
         end else begin
            o = lp ? 8'h02 : 8'h01; // see RULE16
         end
      end
      return o;
   endfunction

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------

   // Everything is decided here; a single register stage holds it all.
   always_comb begin
      logic [7:0] id;
      logic ro;
      logic two;
      logic full;
      logic poll;
      logic [1:0] need140;
      logic [1:0] need141;
      logic need137;
      logic [3:0] n;
      logic req;
      logic [4:0] len;
      s_d = s_q;
      id = s_q.rxBuf[0];
      ro = s_q.rxBuf[1][`EOCSR_BIT_RO];
      two = s_q.ctrl[`EOCSR_CTRL_TWOPAIR];
      full = 1'b0;
      poll = 1'b0;
      need140 = 2'b00;
      need141 = 2'b00;
      need137 = 1'b0;
      n = 4'h0;
      req = avs_read | avs_write;
      len = msgLen(s_q.txId);


      // Register slave: one wait cycle, then the answer stands for one edge.
      s_d.waitReq = ~(req & s_q.waitReq);
      s_d.rdData = 32'h0000_0000;
      if (avs_read & s_q.waitReq) begin
         case (avs_address)
            `EOCSR_REG_CTRL: s_d.rdData = {27'h0, s_q.ctrl};
            `EOCSR_REG_STAT: begin
               s_d.rdData[11:0] = s_q.lbTimeout;
               s_d.rdData[`EOCSR_STAT_FLOWDIS] = s_q.flowDis;
               s_d.rdData[`EOCSR_STAT_CNT +: 4] = {s_q.ovfC, s_q.rstC, s_q.ovfR, s_q.rstR};
               s_d.rdData[`EOCSR_STAT_FAULT] = s_q.devFault;
               s_d.rdData[`EOCSR_STAT_BUSY] = s_q.st != EOCSR_IDLE;
            end
            default: s_d.rdData = 32'h0000_0000;
         endcase
      end
      // A write lands only on the edge that completes the transfer.
      if (avs_write & ~s_q.waitReq & avs_byteenable[0] & (avs_address == `EOCSR_REG_CTRL)) begin
         s_d.ctrl = avs_writedata[4:0];
      end

      // Device fault follows self-test or the software fault bit.
      s_d.devFault = selfTestFail | s_q.ctrl[`EOCSR_CTRL_SWFAULT]; // see RULE22

      // Performance changes since the last poll are sticky until it is planned.
      s_d.netChg = s_q.netChg | netPerfChg; // see RULE12
      s_d.cusChg = s_q.cusChg | cusPerfChg; // see RULE12

      // Clear on a sent network status; a new event in the same cycle wins.
      if (s_q.txValid & txReady & s_q.txLast & (s_q.txId == `EOCSR_ID_NET_RSP)) begin
         if (s_q.txDest) begin
            s_d.ovfR = 1'b0; // see RULE21
            s_d.rstR = 1'b0; // see RULE21
         end else begin
            s_d.ovfC = 1'b0; // see RULE20
            s_d.rstC = 1'b0; // see RULE20
         end
      end
      if (cntWrap) begin
         s_d.ovfC = 1'b1; // see RULE18
         s_d.ovfR = 1'b1; // see RULE18
      end
      if (cntReset) begin
         s_d.rstC = 1'b1; // see RULE19
         s_d.rstR = 1'b1; // see RULE19
      end

      // Transmit register drains on acceptance.
      if (s_q.txValid & txReady) begin
         s_d.txValid = 1'b0;
         s_d.txLast = 1'b0;
      end

      case (s_q.st)
         EOCSR_IDLE, EOCSR_RECV: begin
            if (rxValid & s_q.rxReady) begin
               // Octets past the 22nd are dropped.
               if (s_q.rxCnt < 5'(`EOCSR_RX_MAX)) begin
                  s_d.rxBuf[s_q.rxCnt] = rxData;
                  s_d.rxCnt = s_q.rxCnt + 5'd1;
               end
               if (s_q.st == EOCSR_IDLE) begin
                  s_d.srcRemote = rxRemote;
               end
               s_d.st = rxLast ? EOCSR_PLAN : EOCSR_RECV;
               s_d.rxReady = ~rxLast;
            end
         end
         EOCSR_PLAN: begin
            s_d.unable_to_comply_flag = 1'b0;
            if ((id >= `EOCSR_ID_FLOW_LO) && (id <= `EOCSR_ID_FLOW_HI) && s_q.srcRemote &&
                s_q.flowDis && s_q.ctrl[`EOCSR_CTRL_REGEN]) begin
               n = 4'h0; // see RULE7
            end else if (id == `EOCSR_ID_LBT_REQ) begin
               if (!ro && s_q.ctrl[`EOCSR_CTRL_REFUSE]) begin
                  s_d.unable_to_comply_flag = 1'b1; // see RULE2
               end else if (!ro) begin
                  s_d.lbTimeout = {s_q.rxBuf[1][3:0], s_q.rxBuf[2]}; // see RULE1 see RULE3
               end
               s_d.qId[0] = `EOCSR_ID_LBT_RSP; // see RULE1
               n = 4'h1;
            end else if (id == `EOCSR_ID_MGT_REQ) begin
               if (!ro && s_q.ctrl[`EOCSR_CTRL_REFUSE]) begin
                  s_d.unable_to_comply_flag = 1'b1; // see RULE2
               end else if (!ro) begin
                  s_d.flowDis = s_q.rxBuf[1][`EOCSR_BIT_FLOW]; // see RULE6 see RULE8
               end
               s_d.qId[0] = `EOCSR_ID_MGT_RSP; // see RULE9
               n = 4'h1;
            end else if ((id == `EOCSR_ID_STAT_REQ) || (id == `EOCSR_ID_FULL_REQ)) begin
               full = id == `EOCSR_ID_FULL_REQ;
               poll = ~full;
               need140 = full ? 2'b11 : (netAlarm | s_q.netChg | {2{s_q.devFault}}); // see RULE11
               need141 = full ? 2'b11 : (cusAlarm | s_q.cusChg | {2{s_q.devFault}}); // see RULE12
               need137 = full | maintActive; // see RULE11 see RULE15
               if (!two) begin
                  need140[1] = 1'b0;
                  need141[1] = 1'b0;
               end
               s_d.netChg = netPerfChg;
               s_d.cusChg = cusPerfChg;
               // Network first, then customer, loop 1 before loop 2, maintenance last.
               for (int l = 0; l < 2; l++) begin
                  if (need140[l]) begin
                     s_d.qId[n[2:0]] = `EOCSR_ID_NET_RSP; // see RULE15 see RULE14
                     s_d.qLoop[n[2:0]] = l[0];
                     n = n + 4'h1;
                  end
               end
               for (int l = 0; l < 2; l++) begin
                  if (need141[l]) begin
                     s_d.qId[n[2:0]] = `EOCSR_ID_CUS_RSP; // see RULE15 see RULE14
                     s_d.qLoop[n[2:0]] = l[0];
                     n = n + 4'h1;
                  end
               end
               if (need137) begin
                  s_d.qId[n[2:0]] = `EOCSR_ID_MNT_RSP; // see RULE10
                  n = n + 4'h1;
               end
               if (poll && (n == 4'h0)) begin
                  s_d.qId[0] = `EOCSR_ID_SNR_RSP; // see RULE13
                  s_d.qLoop[0] = 1'b0;
                  s_d.qId[1] = `EOCSR_ID_SNR_RSP; // see RULE14
                  s_d.qLoop[1] = 1'b1;
                  n = two ? 4'h2 : 4'h1; // see RULE10
               end
            end else begin
               n = 4'h0; // see RULE23
            end
            s_d.qLen = n;
            s_d.qIdx = 4'h0;
            s_d.oIdx = 5'd0;
            s_d.rxCnt = 5'd0;
            s_d.st = (n == 4'h0) ? EOCSR_IDLE : EOCSR_SEND;
            s_d.rxReady = n == 4'h0;
         end
         EOCSR_SEND: begin
            if (!s_q.txValid || txReady) begin
               if (s_q.qIdx < s_q.qLen) begin
                  s_d.txId = s_q.qId[s_q.qIdx[2:0]];
                  s_d.txLoop = s_q.qLoop[s_q.qIdx[2:0]];
                  s_d.txDest = s_q.srcRemote;
                  len = msgLen(s_d.txId);
                  s_d.txValid = 1'b1;
                  s_d.txData = octetAt(s_q, s_d.txId, s_d.txLoop, s_q.oIdx);
                  s_d.txLast = s_q.oIdx == (len - 5'd1);
                  if (s_q.oIdx == (len - 5'd1)) begin
                     s_d.oIdx = 5'd0;
                     s_d.qIdx = s_q.qIdx + 4'h1;
                  end else begin
                     s_d.oIdx = s_q.oIdx + 5'd1;
                  end
               end else begin
                  s_d.st = EOCSR_IDLE;
                  s_d.rxReady = 1'b1;
               end
            end
         end
         default: begin
            s_d.st = EOCSR_IDLE;
            s_d.rxReady = 1'b1;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------

   // Counter reset flags start set, since power-up resets every counter.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
         s_q.st <= EOCSR_IDLE;
         s_q.lbTimeout <= `EOCSR_TOUT_RST;
         s_q.flowDis <= 1'b0; // see RULE6
         s_q.ctrl <= `EOCSR_CTRL_RST;
         {s_q.ovfC, s_q.rstC, s_q.ovfR, s_q.rstR} <= `EOCSR_CNTFLG_RST; // see RULE19
         s_q.rxReady <= 1'b1;
         s_q.waitReq <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs, all straight from the state register
   // -----------------------------------------------------------------
   assign avs_readdata = s_q.rdData;
   assign avs_waitrequest = s_q.waitReq;
   assign rxReady = s_q.rxReady;
   assign txValid = s_q.txValid;
   assign txData = s_q.txData;
   assign txLast = s_q.txLast;
   assign txLoop = s_q.txLoop;
   assign cntFlags = {s_q.ovfC, s_q.rstC, s_q.ovfR, s_q.rstR};
   assign devFaultFlag = s_q.devFault;

endmodule
`default_nettype wire

/* File: core/eocsr_defs.svh */
// Constants for the embedded operations channel status and configuration responder.
`ifndef EOCSR_DEFS_SVH
`define EOCSR_DEFS_SVH

// -----------------------------------------------------------------
// Message identifiers
// -----------------------------------------------------------------
`define EOCSR_ID_LBT_REQ 8'h05
`define EOCSR_ID_LBT_RSP 8'h85
`define EOCSR_ID_MGT_REQ 8'h12
`define EOCSR_ID_MGT_RSP 8'h92
`define EOCSR_ID_STAT_REQ 8'h0b
`define EOCSR_ID_FULL_REQ 8'h0c
`define EOCSR_ID_SNR_RSP 8'h8b
`define EOCSR_ID_NET_RSP 8'h8c
`define EOCSR_ID_CUS_RSP 8'h8d
`define EOCSR_ID_MNT_RSP 8'h89
`define EOCSR_ID_FLOW_LO 8'h02
`define EOCSR_ID_FLOW_HI 8'h0c

// -----------------------------------------------------------------
// Message lengths and field positions
// -----------------------------------------------------------------
`define EOCSR_RX_MAX 22
`define EOCSR_LEN_LBT 5'd22
`define EOCSR_LEN_MGT 5'd3
`define EOCSR_LEN_SNR 5'd4
`define EOCSR_LEN_ONE 5'd1
`define EOCSR_BIT_RO 7
`define EOCSR_BIT_UTC 0
`define EOCSR_BIT_FLOW 0
`define EOCSR_DT_FIRST 5'd4
`define EOCSR_DT_SHIFT 5'd1

// -----------------------------------------------------------------
// Register map (byte addresses) and control bits
// -----------------------------------------------------------------
`define EOCSR_REG_CTRL 4'h0
`define EOCSR_REG_STAT 4'h4
`define EOCSR_CTRL_TWOPAIR 0
`define EOCSR_CTRL_CENTRAL 1
`define EOCSR_CTRL_REGEN 2
`define EOCSR_CTRL_REFUSE 3
`define EOCSR_CTRL_SWFAULT 4
`define EOCSR_CTRL_RST 5'h00
`define EOCSR_STAT_FLOWDIS 12
`define EOCSR_STAT_CNT 16
`define EOCSR_STAT_FAULT 20
`define EOCSR_STAT_BUSY 21

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define EOCSR_TOUT_RST 12'h000
`define EOCSR_CNTFLG_RST 4'h5

`endif

/* File: core/eocsr_pkg.sv */
// Types for the embedded operations channel status and configuration responder.
package eocsr_pkg;

   // Gray-coded sequencing states.
   typedef enum logic [1:0] {
      EOCSR_IDLE = 2'b00,
      EOCSR_RECV = 2'b01,
      EOCSR_PLAN = 2'b11,
      EOCSR_SEND = 2'b10
   } eocsr_state_t;

   // Whole state of the responder.
   typedef struct packed {
      eocsr_state_t st;
      logic [21:0][7:0] rxBuf;
      logic [4:0] rxCnt;
      logic srcRemote;
      logic [7:0][7:0] qId;
      logic [7:0] qLoop;
      logic [3:0] qLen;
      logic [3:0] qIdx;
      logic [4:0] oIdx;
      logic unable_to_comply_flag;
      logic [11:0] lbTimeout;
      logic flowDis;
      logic [4:0] ctrl;
      logic ovfC;
      logic rstC;
      logic ovfR;
      logic rstR;
      logic [1:0] netChg;
      logic [1:0] cusChg;
      logic [7:0] txId;
      logic txDest;
      logic txValid;
      logic [7:0] txData;
      logic txLast;
      logic txLoop;
      logic rxReady;
      logic devFault;
      logic waitReq;
      logic [31:0] rdData;
   } eocsr_state_s_t;

endpackage

/* File: sim/eocsr_chk.sv */
// Concurrent checks on the responder's message streams and flags.
`timescale 1ns/1ps
`default_nettype none
module eocsr_chk (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Message streams.
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxLast,
   input wire logic rxReady,
   input wire logic txValid,
   input wire logic [7:0] txData,
   input wire logic txLast,
   input wire logic txLoop,
   input wire logic txReady,
   // Conditions and flags.
   input wire logic selfTestFail,
   input wire logic cntWrap,
   input wire logic cntReset,
   input wire logic [3:0] cntFlags,
   input wire logic devFaultFlag
);
   // ------------------------------
   // Message tracking
   // ------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic [4:0] idx_q;
   logic [7:0] txId_q, rxId_q, pend_q, txId, rxId;
   logic rxFirst_q, txAcc, rxEnd;
   // Ids are kept so that later octets can be judged by their message.
   assign txAcc = txValid && txReady;
   assign txId = (idx_q == 5'd0) ? txData : txId_q;
   assign rxId = rxFirst_q ? rxData : rxId_q;
   assign rxEnd = rxValid && rxReady && rxLast;
   // Position in response, and the poll still waiting for its first octet.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         idx_q <= 5'd0;
         txId_q <= 8'h00;
         rxId_q <= 8'h00;
         pend_q <= 8'h00;
         rxFirst_q <= 1'b1;
      end else begin
         if (txAcc) begin
            idx_q <= txLast ? 5'd0 : idx_q + 5'd1;
            txId_q <= txId;
            pend_q <= 8'h00;
         end
         if (rxValid && rxReady) begin
            rxFirst_q <= rxLast;
            rxId_q <= rxId;
            pend_q <= rxLast ? rxId : 8'h00;
         end
      end
   end
   sequence s_status_first;
      txData inside {8'h8b, 8'h8c, 8'h8d, 8'h89};
   endsequence
   sequence s_silent;
      !txValid [*4];
   endsequence
   a_wrap_sets_ovf: assert property (cntWrap |=> cntFlags[3] && cntFlags[1])
      else $error("overflow flags not set after wrap");
   a_reset_sets_rst: assert property (cntReset |=> cntFlags[2] && cntFlags[0])
      else $error("reset flags not set after counter reset");
   a_central_clear: assert property (($fell(cntFlags[3]) || $fell(cntFlags[2]))
      |-> $past(txAcc && txLast && txId == 8'h8c)) else $error("central flags cleared early");
   a_remote_clear: assert property (($fell(cntFlags[1]) || $fell(cntFlags[0]))
      |-> $past(txAcc && txLast && txId == 8'h8c)) else $error("remote flags cleared early");
   a_fault_follows: assert property (selfTestFail |=> devFaultFlag)
      else $error("device fault flag missing");
   a_snr_loop_id: assert property (txAcc && txId == 8'h8b && idx_q == 5'd3
      |-> txLast && txData == {7'h00, txLoop} + 8'h01) else $error("bad loop id in 139");
   a_lbt_length: assert property (txAcc && txId == 8'h85 |-> txLast == (idx_q == 5'd21))
      else $error("133 length wrong");
   a_mgt_length: assert property (txAcc && txId == 8'h92 |-> txLast == (idx_q == 5'd2))
      else $error("146 length wrong");
   a_poll_answer: assert property (txAcc && pend_q == 8'h0b |-> s_status_first)
      else $error("poll answered with non-status id");
   a_full_order: assert property (txAcc && pend_q == 8'h0c |-> txData == 8'h8c)
      else $error("full status not led by 140");
   a_unknown_quiet: assert property (rxEnd && !(rxId inside {8'h05, 8'h12, 8'h0b, 8'h0c})
      |=> s_silent) else $error("unknown id answered");
endmodule
bind eocsr_responder eocsr_chk chk (.*);
`default_nettype wire

/* File: sim/eocsr_far.sv */
// Far-end management logic model: sends requests and sinks responses.
`timescale 1ns/1ps
`default_nettype none
module eocsr_far (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Requests toward the unit.
   output logic rxValid,
   output logic [7:0] rxData,
   output logic rxLast,
   output logic rxRemote,
   input wire logic rxReady,
   // Responses from the unit.
   input wire logic txValid,
   input wire logic [7:0] txData,
   input wire logic txLast,
   output logic txReady,
   input wire logic slow
);
   logic [7:0] got[$];
   logic tog;
   initial begin
      rxValid = 1'b0;
      rxData = 8'h00;
      rxLast = 1'b0;
      rxRemote = 1'b0;
   end
   // Slow mode takes every other octet, so the unit must hold its output.
   assign txReady = !slow || tog;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tog <= 1'b0;
      end else begin
         tog <= ~tog;
         if (txValid && txReady) begin
            got.push_back(txData);
         end
      end
   end
   // Sends one whole message; no address, so 18 reaches the unit as a broadcast.
   task automatic send(input logic [7:0] m[$], input logic rem, output bit ok);
      int n;
      ok = 1'b1;
      got.delete();
      foreach (m[i]) begin
         rxValid <= 1'b1;
         rxData <= m[i];
         rxLast <= (i == m.size() - 1);
         rxRemote <= rem;
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (!rxReady && n < 100);
         if (n >= 100) ok = 1'b0;
      end
      // A released line shows the inverse, never a stale copy.
      rxValid <= 1'b0;
      rxLast <= 1'b0;
      rxData <= ~rxData;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while ((!rxReady || n < 3) && n < 300);
      if (n >= 300) ok = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the operations channel responder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef logic [7:0] eocsr_bytes_t[$];
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic rxValid, rxLast, rxRemote, rxReady, txValid, txLast, txLoop, txReady;
   logic [7:0] rxData, txData;
   logic [1:0][7:0] snrNet = {8'h0d, 8'h0c}, snrCus = {8'h7f, 8'h14};
   logic [1:0] netAlarm = 2'b00, cusAlarm = 2'b00, netPerfChg = 2'b00, cusPerfChg = 2'b00;
   logic maintActive = 1'b0, selfTestFail = 1'b0, cntWrap = 1'b0, cntReset = 1'b0;
   logic slow = 1'b0, devFaultFlag;
   logic [3:0] cntFlags;
   int mismatches = 0, compares = 0;
   bit ok;
   eocsr_bytes_t nil;
   always #5 sys_clk = ~sys_clk;
   eocsr_responder uut (.*, .avs_byteenable(4'hf));
   eocsr_far far (.*);
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One Avalon access, held until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest && n < 50);
      rd = avs_readdata;
      if (n >= 50) begin
         mismatches++;
         finish_test();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic ctrl(input logic [4:0] v);
      bus(1'b1, 4'h0, {27'h0, v});
   endtask
   // Timeout request or 133 answer: header, then 18 date and time octets.
   function automatic eocsr_bytes_t lbt(input eocsr_bytes_t h);
      eocsr_bytes_t q;
      q = h;
      for (int i = 0; i < 18; i++) begin
         q.push_back(8'h30 + 8'(i));
      end
      return q;
   endfunction
   task automatic msg(input eocsr_bytes_t m, input logic rem, input eocsr_bytes_t e);
      far.send(m, rem, ok);
      if (!ok) begin
         mismatches++;
         finish_test();
      end
      chk(32'(far.got.size()), 32'(e.size()));
      foreach (e[i]) begin
         chk({24'h0, far.got[i]}, {24'h0, e[i]});
      end
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   // ------------------------------
   // Stimulus
   // ------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      chk(32'(cntFlags), 32'h5);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h0005_0000);
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h0);
      done("reset");
      slow <= 1'b1;
      msg(lbt('{8'h05, 8'h0a, 8'hbc}), 1'b0, lbt('{8'h85, 8'h00, 8'h0a, 8'hbc}));
      slow <= 1'b0;
      msg(lbt('{8'h05, 8'h83, 8'h21}), 1'b0, lbt('{8'h85, 8'h00, 8'h0a, 8'hbc}));
      ctrl(5'h08);
      msg(lbt('{8'h05, 8'h01, 8'h23}), 1'b0, lbt('{8'h85, 8'h01, 8'h0a, 8'hbc}));
      msg('{8'h12, 8'h00}, 1'b0, '{8'h92, 8'h01, 8'h00});
      ctrl(5'h00);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h0005_0abc);
      msg('{8'h12, 8'h01}, 1'b0, '{8'h92, 8'h00, 8'h01});
      msg('{8'h12, 8'h80}, 1'b0, '{8'h92, 8'h00, 8'h01});
      ctrl(5'h04);
      msg('{8'h0b}, 1'b1, nil);
      msg('{8'h0b}, 1'b0, '{8'h8b, 8'h0c, 8'h00, 8'h01});
      msg('{8'h12, 8'h00}, 1'b0, '{8'h92, 8'h00, 8'h00});
      done("config");
      ctrl(5'h02);
      msg('{8'h0b}, 1'b1, '{8'h8b, 8'h00, 8'h14, 8'h01});
      ctrl(5'h03);
      msg('{8'h0b}, 1'b0, '{8'h8b, 8'h00, 8'h14, 8'h01, 8'h8b, 8'h00, 8'h7f, 8'h02});
      ctrl(5'h00);
      netAlarm <= 2'b01;
      msg('{8'h0b}, 1'b0, '{8'h8c});
      chk(32'(cntFlags), 32'h1);
      msg('{8'h0b}, 1'b1, '{8'h8c});
      chk(32'(cntFlags), 32'h0);
      netAlarm <= 2'b00;
      cntWrap <= 1'b1;
      @(posedge sys_clk);
      cntWrap <= 1'b0;
      cntReset <= 1'b1;
      @(posedge sys_clk);
      cntReset <= 1'b0;
      @(posedge sys_clk);
      chk(32'(cntFlags), 32'hf);
      cusPerfChg <= 2'b01;
      @(posedge sys_clk);
      cusPerfChg <= 2'b00;
      msg('{8'h0b}, 1'b0, '{8'h8d});
      msg('{8'h0b}, 1'b0, '{8'h8b, 8'h0c, 8'h00, 8'h01});
      ctrl(5'h01);
      maintActive <= 1'b1;
      msg('{8'h0c}, 1'b0, '{8'h8c, 8'h8c, 8'h8d, 8'h8d, 8'h89});
      msg('{8'h0b}, 1'b0, '{8'h89});
      maintActive <= 1'b0;
      ctrl(5'h00);
      done("status");
      selfTestFail <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk(32'(devFaultFlag), 32'h1);
      msg('{8'h0b}, 1'b0, '{8'h8c, 8'h8d});
      selfTestFail <= 1'b0;
      ctrl(5'h10);
      bus(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h10);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h0013_0abc);
      ctrl(5'h00);
      msg('{8'h40, 8'h01}, 1'b0, nil);
      msg('{8'h92}, 1'b1, nil);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h0003_0abc);
      done("fault");
      finish_test();
   end
endmodule
`default_nettype wire
